// >>> hw/adcs_sequencer.sv
// Summary of operation
// RL1: sixteen inputs muxed, ten bit result each
// RL2: unread result overwritten raises overrun interrupt
// RL3: protection mode suspends next conversion until read
// RL4: single mode converts channel once, then stops
// RL5: continuous mode repeats selected channel forever
// RL6: scan single converts each channel once, events
// RL7: scan continuous cycles through channels without stop
// RL8: wait-for-read buffers result, holds until read
// RL9: injected conversion goes to injection register, resumes
// RL10: conversion lasts 14 cc, 2 sc, 4 half-periods
// RL11: conversion clock code picks 24, 96, 48
// RL12: sample clock is 1,2,4,8 conversion clocks
// RL13: reset calibration 1.6 ms keeps busy set
// RL14: conversions during reset calibration extend it
// RL15: four clock calibration cycle after each conversion
// RL16: unused analog inputs readable as digital pins
// RL17: software configures before start, not while busy
// RL18: half oscillator period is divider base unit
`timescale 1ns/1ps
`include "adcs_consts.svh"

module adcs_sequencer
#(
  parameter int RESET_CAL_CYCLES = (`ADCS_RESET_CAL_PS + `ADCS_CLK_PS - 1) / `ADCS_CLK_PS,
  parameter int TCL_CYCLES       = `ADCS_TCL_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       ana_channel_q,
  output logic             ana_sample_q,
  output logic             ana_convert_q,
  output logic             ana_calibrate_q,
  input  wire logic [9:0]  ana_result,
  input  wire logic [15:0] port_pins,
  output logic             irq_q
);

  localparam int CW = $clog2(RESET_CAL_CYCLES + 1);

  adcs_pkg::adcs_state_t st_q;
  adcs_pkg::adcs_mode_t  mode_q;
  logic [3:0]  chan_sel_q;
  logic [3:0]  cur_ch_q;
  logic [3:0]  conv_ch_q;
  logic [3:0]  inj_ch_q;
  logic        protect_q;
  logic        wfr_q;
  logic [1:0]  ctc_q;
  logic [1:0]  stc_q;
  logic        run_q;
  logic        inj_pend_q;
  logic        doing_inj_q;
  logic        unread_q;
  logic [4:0]  cnt_q;
  logic [9:0]  result_q;
  logic [3:0]  result_ch_q;
  logic [9:0]  inj_result_q;
  logic [3:0]  inj_ch_res_q;
  logic [9:0]  temp_q;
  logic [2:0]  status_q;
  logic [2:0]  mask_q;
  logic [CW-1:0] rcal_cnt_q;
  logic        busy_q;
  logic [15:0] pins_meta_q;
  logic [15:0] pins_q;
  logic        tcl_tick;
  logic        cc_tick;
  logic        wr_go;
  logic        rd_go;
  logic        rd_res;
  logic        ctrl_wr;
  logic        phase_tick;
  logic        phase_end;
  logic        continuous;
  logic        store_res;
  logic        store_inj;
  logic        start_ok;
  logic        wr_ok;
  logic        rd_ok;
  logic [4:0]  sample_len;
  logic [31:0] rd_mux;

  adcs_timebase #(.TCL_CYCLES(TCL_CYCLES)) u_timebase
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ctc        (ctc_q),
    .tcl_tick_q (tcl_tick),
    .cc_tick_q  (cc_tick)
  );

  // ---------------- bus slave ----------------
  // address and data are taken together; one write and one read at a time
  assign wr_go   = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go   = s_axi_arready && s_axi_arvalid;
  assign rd_res  = rd_go && (s_axi_araddr == `ADCS_OFS_RESULT);
  assign ctrl_wr = wr_go && (s_axi_awaddr == `ADCS_OFS_CTRL) && s_axi_wstrb[0] && s_axi_wstrb[2];

  always_comb
  begin
    wr_ok = 1'b1;
    if (s_axi_awaddr == `ADCS_OFS_CTRL || s_axi_awaddr == `ADCS_OFS_STATUS)
      wr_ok = 1'b1;
    else if (s_axi_awaddr == `ADCS_OFS_MASK)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    if (s_axi_araddr == `ADCS_OFS_CTRL)
    begin
      rd_mux[`ADCS_CTRL_CH_LSB +: 4]   = chan_sel_q;
      rd_mux[`ADCS_CTRL_MODE_LSB +: 2] = mode_q;
      rd_mux[`ADCS_CTRL_BUSY]          = busy_q; // RL13
      rd_mux[`ADCS_CTRL_PROTECT]       = protect_q;
      rd_mux[`ADCS_CTRL_WFR]           = wfr_q;
      rd_mux[`ADCS_CTRL_CTC_LSB +: 2]  = ctc_q;
      rd_mux[`ADCS_CTRL_STC_LSB +: 2]  = stc_q;
      rd_mux[`ADCS_CTRL_INJ_LSB +: 4]  = inj_ch_q;
      rd_mux[`ADCS_CTRL_INJ_GO]        = inj_pend_q;
    end
    else if (s_axi_araddr == `ADCS_OFS_RESULT)
      rd_mux = {16'h0, result_ch_q, 2'h0, result_q};
    else if (s_axi_araddr == `ADCS_OFS_INJ)
      rd_mux = {16'h0, inj_ch_res_q, 2'h0, inj_result_q};
    else if (s_axi_araddr == `ADCS_OFS_STATUS)
      rd_mux = {29'h0, status_q};
    else if (s_axi_araddr == `ADCS_OFS_MASK)
      rd_mux = {29'h0, mask_q};
    else if (s_axi_araddr == `ADCS_OFS_PINS)
      rd_mux = {16'h0, pins_q}; // RL16
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // digital view of the analog pins; only the second stage is read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pins_meta_q <= 16'h0;
      pins_q      <= 16'h0;
    end
    else
    begin
      pins_meta_q <= port_pins;
      pins_q      <= pins_meta_q; // RL16
    end
  end

  // ---------------- configuration ----------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chan_sel_q <= 4'h0;
      mode_q     <= adcs_pkg::ADCS_MODE_SINGLE;
      protect_q  <= 1'b0;
      wfr_q      <= 1'b0;
      ctc_q      <= 2'h0;
      stc_q      <= 2'h0;
      inj_ch_q   <= 4'h0;
      mask_q     <= 3'h0;
    end
    else if (wr_go)
    begin
      if (ctrl_wr)
      begin
        chan_sel_q <= s_axi_wdata[`ADCS_CTRL_CH_LSB +: 4];
        mode_q     <= adcs_pkg::adcs_mode_t'(s_axi_wdata[`ADCS_CTRL_MODE_LSB +: 2]);
        protect_q  <= s_axi_wdata[`ADCS_CTRL_PROTECT];
        wfr_q      <= s_axi_wdata[`ADCS_CTRL_WFR];
        ctc_q      <= s_axi_wdata[`ADCS_CTRL_CTC_LSB +: 2]; // RL11
        stc_q      <= s_axi_wdata[`ADCS_CTRL_STC_LSB +: 2]; // RL12
        inj_ch_q   <= s_axi_wdata[`ADCS_CTRL_INJ_LSB +: 4];
      end
      else if (s_axi_awaddr == `ADCS_OFS_MASK && s_axi_wstrb[0])
        mask_q <= s_axi_wdata[2:0];
    end
  end

  // ---------------- sequencer ----------------
  assign continuous = mode_q[0];
  assign sample_len = (`ADCS_SAMPLE_TSC << stc_q) - 5'h01; // RL12 RL10
  assign phase_tick = (st_q == adcs_pkg::ADCS_XFER) ? tcl_tick : cc_tick;
  assign phase_end  = phase_tick && (cnt_q == 5'h0);
  // no new regular conversion while the last result is unread and protection is on; a pending injection still starts
  assign start_ok   = !(protect_q && unread_q); // RL3
  assign store_res  = phase_end && (st_q == adcs_pkg::ADCS_XFER) && !doing_inj_q
                      && !(wfr_q && continuous && unread_q)
                      || (st_q == adcs_pkg::ADCS_HOLD && rd_res);
  assign store_inj  = phase_end && (st_q == adcs_pkg::ADCS_XFER) && doing_inj_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q        <= adcs_pkg::ADCS_IDLE;
      cnt_q       <= 5'h0;
      conv_ch_q   <= 4'h0;
      doing_inj_q <= 1'b0;
      temp_q      <= 10'h0;
    end
    else
    begin
      case (st_q)
        adcs_pkg::ADCS_IDLE:
        begin
          cnt_q <= sample_len;
          if (inj_pend_q && run_q && continuous)
          begin
            doing_inj_q <= 1'b1; // RL9
            conv_ch_q   <= inj_ch_q;
            st_q        <= adcs_pkg::ADCS_SAMPLE;
          end
          else if (run_q && start_ok)
          begin
            doing_inj_q <= 1'b0;
            conv_ch_q   <= cur_ch_q; // RL1
            st_q        <= adcs_pkg::ADCS_SAMPLE;
          end
        end
        adcs_pkg::ADCS_SAMPLE:
        begin
          if (phase_end)
          begin
            cnt_q <= `ADCS_CONV_CC - 5'h01;
            st_q  <= adcs_pkg::ADCS_CONVERT;
          end
          else if (cc_tick)
            cnt_q <= cnt_q - 5'h01;
        end
        adcs_pkg::ADCS_CONVERT:
        begin
          if (phase_end)
          begin
            cnt_q <= `ADCS_XFER_TCL - 5'h01; // RL10
            st_q  <= adcs_pkg::ADCS_XFER;
          end
          else if (cc_tick)
            cnt_q <= cnt_q - 5'h01;
        end
        adcs_pkg::ADCS_XFER:
        begin
          if (phase_end)
          begin
            cnt_q <= `ADCS_CAL_CC - 5'h01;
            if (!doing_inj_q && wfr_q && continuous && unread_q)
            begin
              temp_q <= ana_result; // RL8
              st_q   <= adcs_pkg::ADCS_HOLD;
            end
            else
              st_q <= adcs_pkg::ADCS_CAL;
          end
          else if (tcl_tick)
            cnt_q <= cnt_q - 5'h01;
        end
        adcs_pkg::ADCS_HOLD:
        begin
          if (rd_res)
            st_q <= adcs_pkg::ADCS_CAL; // RL8
        end
        adcs_pkg::ADCS_CAL:
        begin
          if (phase_end)
            st_q <= adcs_pkg::ADCS_IDLE; // RL15
          else if (cc_tick)
            cnt_q <= cnt_q - 5'h01;
        end
        default:
          st_q <= adcs_pkg::ADCS_IDLE;
      endcase
    end
  end

  // run control and channel walk; scans count down from the selected channel to 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q    <= 1'b0;
      cur_ch_q <= 4'h0;
    end
    else if (ctrl_wr && s_axi_wdata[`ADCS_CTRL_START])
    begin
      run_q    <= 1'b1;
      cur_ch_q <= s_axi_wdata[`ADCS_CTRL_CH_LSB +: 4];
    end
    else if (store_res)
    begin
      if (mode_q == adcs_pkg::ADCS_MODE_SINGLE)
        run_q <= 1'b0; // RL4
      else if (mode_q[1] && cur_ch_q != 4'h0)
        cur_ch_q <= cur_ch_q - 4'h1; // RL6 RL7
      else if (mode_q == adcs_pkg::ADCS_MODE_SCAN_SINGLE)
        run_q <= 1'b0; // RL6
      else if (mode_q == adcs_pkg::ADCS_MODE_SCAN_CONT)
        cur_ch_q <= chan_sel_q; // RL7
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      inj_pend_q <= 1'b0;
    else if (ctrl_wr && s_axi_wdata[`ADCS_CTRL_INJ_GO])
      inj_pend_q <= 1'b1;
    else if (st_q == adcs_pkg::ADCS_IDLE && run_q && continuous)
      inj_pend_q <= 1'b0; // RL9
    else if (!run_q || !continuous)
      inj_pend_q <= 1'b0;
  end

  // result registers; the held copy is released by the read that frees the register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_q     <= 10'h0;
      result_ch_q  <= 4'h0;
      inj_result_q <= 10'h0;
      inj_ch_res_q <= 4'h0;
    end
    else
    begin
      if (store_res)
      begin
        result_q    <= (st_q == adcs_pkg::ADCS_HOLD) ? temp_q : ana_result; // RL5 RL7
        result_ch_q <= conv_ch_q;
      end
      if (store_inj)
      begin
        inj_result_q <= ana_result; // RL9
        inj_ch_res_q <= conv_ch_q;
      end
    end
  end

  // a store in the same cycle as the read keeps the flag set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      unread_q <= 1'b0;
    else if (store_res)
      unread_q <= 1'b1;
    else if (rd_res)
      unread_q <= 1'b0;
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_go && s_axi_awaddr == `ADCS_OFS_STATUS && s_axi_wstrb[0] && s_axi_wdata[i])
          status_q[i] <= 1'b0;
      end
      if (store_res)
        status_q[`ADCS_ST_DONE] <= 1'b1; // RL6
      if (store_res && unread_q && !protect_q && st_q != adcs_pkg::ADCS_HOLD)
        status_q[`ADCS_ST_OVERRUN] <= 1'b1; // RL2
      if (store_inj)
        status_q[`ADCS_ST_INJ] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end

  // reset calibration only advances while no conversion runs, so it stretches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rcal_cnt_q <= CW'(RESET_CAL_CYCLES);
    else if (rcal_cnt_q != '0 && st_q == adcs_pkg::ADCS_IDLE)
      rcal_cnt_q <= rcal_cnt_q - CW'(1); // RL14
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q          <= 1'b1;
      ana_channel_q   <= 4'h0;
      ana_sample_q    <= 1'b0;
      ana_convert_q   <= 1'b0;
      ana_calibrate_q <= 1'b0;
    end
    else
    begin
      busy_q          <= rcal_cnt_q != '0 || run_q || st_q != adcs_pkg::ADCS_IDLE; // RL13
      ana_channel_q   <= conv_ch_q; // RL1
      ana_sample_q    <= st_q == adcs_pkg::ADCS_SAMPLE;
      ana_convert_q   <= st_q == adcs_pkg::ADCS_CONVERT;
      ana_calibrate_q <= st_q == adcs_pkg::ADCS_CAL
                         || (rcal_cnt_q != '0 && st_q == adcs_pkg::ADCS_IDLE); // RL15
    end
  end

  chk_busy_in_cal: assert property ( // RL13
    @(posedge aclk) disable iff (!aresetn)
    (rcal_cnt_q != '0) |=> busy_q)
    else $error("busy low during reset calibration");

  chk_overrun_flag: assert property ( // RL2
    @(posedge aclk) disable iff (!aresetn)
    (store_res && unread_q && !protect_q && st_q == adcs_pkg::ADCS_XFER)
    |=> status_q[`ADCS_ST_OVERRUN])
    else $error("overrun not flagged");

  chk_suspend_start: assert property ( // RL3
    @(posedge aclk) disable iff (!aresetn)
    (st_q == adcs_pkg::ADCS_IDLE && protect_q && unread_q && !inj_pend_q)
    |=> st_q != adcs_pkg::ADCS_SAMPLE)
    else $error("conversion started over unread result");

  chk_single_stop: assert property ( // RL4
    @(posedge aclk) disable iff (!aresetn)
    (store_res && mode_q == adcs_pkg::ADCS_MODE_SINGLE && !ctrl_wr) |=> !run_q)
    else $error("single mode did not stop");

  chk_conv_to_xfer: assert property ( // RL10
    @(posedge aclk) disable iff (!aresetn)
    (st_q == adcs_pkg::ADCS_CONVERT && phase_end)
    |=> st_q == adcs_pkg::ADCS_XFER && cnt_q == `ADCS_XFER_TCL - 5'h01)
    else $error("conversion phase did not end into transfer");

  chk_wfr_hold: assert property ( // RL8
    @(posedge aclk) disable iff (!aresetn)
    (st_q == adcs_pkg::ADCS_HOLD && !rd_res) |=> st_q == adcs_pkg::ADCS_HOLD
    && $stable(result_q))
    else $error("held result released without read");

  chk_inj_resume: assert property ( // RL9
    @(posedge aclk) disable iff (!aresetn)
    (store_inj && !wr_go) |=> run_q && $stable(mode_q) && $stable(result_q)
    && st_q == adcs_pkg::ADCS_CAL)
    else $error("injection disturbed the running mode");

  chk_cal_after_conv: assert property ( // RL15
    @(posedge aclk) disable iff (!aresetn)
    (st_q == adcs_pkg::ADCS_XFER && phase_end)
    |=> (st_q == adcs_pkg::ADCS_CAL || st_q == adcs_pkg::ADCS_HOLD)
    && cnt_q == `ADCS_CAL_CC - 5'h01)
    else $error("no calibration cycle armed after conversion");

endmodule

// >>> hw/adcs_consts.svh
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

// register byte offsets
`define ADCS_OFS_CTRL      8'h00
`define ADCS_OFS_RESULT    8'h04
`define ADCS_OFS_INJ       8'h08
`define ADCS_OFS_STATUS    8'h0c
`define ADCS_OFS_MASK      8'h10
`define ADCS_OFS_PINS      8'h14

// control register fields
`define ADCS_CTRL_CH_LSB   0
`define ADCS_CTRL_MODE_LSB 4
`define ADCS_CTRL_START    6
`define ADCS_CTRL_BUSY     7
`define ADCS_CTRL_PROTECT  8
`define ADCS_CTRL_WFR      9
`define ADCS_CTRL_CTC_LSB  10
`define ADCS_CTRL_STC_LSB  12
`define ADCS_CTRL_INJ_LSB  14
`define ADCS_CTRL_INJ_GO   18

// result registers: data in the low bits, channel above
`define ADCS_RES_CH_LSB    12

// status and mask bits
`define ADCS_ST_DONE       0
`define ADCS_ST_OVERRUN    1
`define ADCS_ST_INJ        2

// timing, in half oscillator periods, conversion clocks, sample clocks, clock cycles or picoseconds
`define ADCS_CC_DIV_00     7'd24
`define ADCS_CC_DIV_10     7'd96
`define ADCS_CC_DIV_11     7'd48
`define ADCS_CONV_CC       5'd14
`define ADCS_XFER_TCL      5'd4
`define ADCS_CAL_CC        5'd4
`define ADCS_SAMPLE_TSC    5'd2
`define ADCS_TCL_CYCLES    4
`define ADCS_CLK_PS        5000
`define ADCS_RESET_CAL_PS  1600000000

`endif

// >>> hw/adcs_pkg.sv
package adcs_pkg;

  typedef enum logic [5:0]
  {
    ADCS_IDLE    = 6'b000001,
    ADCS_SAMPLE  = 6'b000010,
    ADCS_CONVERT = 6'b000100,
    ADCS_XFER    = 6'b001000,
    ADCS_HOLD    = 6'b010000,
    ADCS_CAL     = 6'b100000
  } adcs_state_t;

  typedef enum logic [1:0]
  {
    ADCS_MODE_SINGLE      = 2'h0,
    ADCS_MODE_CONTINUOUS  = 2'h1,
    ADCS_MODE_SCAN_SINGLE = 2'h2,
    ADCS_MODE_SCAN_CONT   = 2'h3
  } adcs_mode_t;

endpackage

// >>> hw/adcs_timebase.sv
`timescale 1ns/1ps
`include "adcs_consts.svh"

module adcs_timebase
#(
  parameter int TCL_CYCLES = `ADCS_TCL_CYCLES
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] ctc,
  output logic            tcl_tick_q,
  output logic            cc_tick_q
);

  logic [7:0] pre_q;
  logic [6:0] tcl_cnt_q;
  logic [6:0] div;

  // reserved code 01 falls back to the fastest setting
  always_comb
  begin
    if (ctc == 2'h2)
      div = `ADCS_CC_DIV_10;
    else if (ctc == 2'h3)
      div = `ADCS_CC_DIV_11;
    else
      div = `ADCS_CC_DIV_00;
  end

  // half oscillator period as base unit of every divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_q <= 8'h00;
    else if (pre_q == 8'(TCL_CYCLES - 1))
      pre_q <= 8'h00;
    else
      pre_q <= pre_q + 8'h01; // RL18
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tcl_cnt_q  <= 7'h00;
      tcl_tick_q <= 1'b0;
      cc_tick_q  <= 1'b0;
    end
    else
    begin
      tcl_tick_q <= (pre_q == 8'(TCL_CYCLES - 1));
      cc_tick_q  <= 1'b0;
      if (pre_q == 8'(TCL_CYCLES - 1))
      begin
        if (tcl_cnt_q >= div - 7'h01)
        begin
          tcl_cnt_q <= 7'h00;
          cc_tick_q <= 1'b1; // RL11
        end
        else
          tcl_cnt_q <= tcl_cnt_q + 7'h01;
      end
    end
  end

endmodule

// >>> test/adcs_analog_model.sv
`timescale 1ns/1ps
module adcs_analog_model
(
  input  wire logic [3:0] ana_channel_q,
  output logic      [9:0] ana_result
);
  // one fixed code per channel, so a wrong channel shows in the result
  assign ana_result = {ana_channel_q, 6'h15};
endmodule

// >>> test/adcs_sequencer_tb.sv
`timescale 1ns/1ps
module adcs_sequencer_tb;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  ana_channel_q;
  logic        ana_sample_q;
  logic        ana_convert_q;
  logic        ana_calibrate_q;
  logic [9:0]  ana_result;
  logic [15:0] port_pins;
  logic        irq_q;
  int          mismatches = 0;
  int          n_compared = 0;
  int          s_n = 0;
  int          c_n = 0;
  int          k_n = 0;
  int          s_len = 0;
  int          c_len = 0;
  int          k_len = 0;
  int          div_t[4] = '{24, 96, 48, 24};
  int          ctc_t[4] = '{0, 2, 3, 0};
  int          stc_t[4] = '{0, 1, 3, 2};

  adcs_sequencer #(.RESET_CAL_CYCLES(50), .TCL_CYCLES(1)) adcs_sequencer_i
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ana_channel_q(ana_channel_q), .ana_sample_q(ana_sample_q),
    .ana_convert_q(ana_convert_q), .ana_calibrate_q(ana_calibrate_q),
    .ana_result(ana_result), .port_pins(port_pins), .irq_q(irq_q)
  );

  adcs_analog_model adcs_analog_model_i
  (
    .ana_channel_q(ana_channel_q),
    .ana_result(ana_result)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // run lengths of each analog phase, latched when the phase ends
  always @(posedge aclk)
  begin
    s_n <= ana_sample_q ? s_n + 1 : 0;
    c_n <= ana_convert_q ? c_n + 1 : 0;
    k_n <= ana_calibrate_q ? k_n + 1 : 0;
    if (!ana_sample_q && s_n != 0) s_len <= s_n;
    if (!ana_convert_q && c_n != 0) c_len <= c_n;
    if (!ana_calibrate_q && k_n != 0) k_len <= k_n;
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // ready lines stay high throughout, so back-to-back calls never re-drive them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wst(input int b);
    logic [31:0] v;
    logic [1:0]  r;
    for (int i = 0; i < 4000; i++)
    begin
      rd(8'h0c, v, r);
      if (v[b] === 1'b1) break;
    end
    chk({31'h0, v[b]}, 32'h1);
  endtask

  function automatic logic [31:0] cw(input logic [3:0] ch, input logic [1:0] md,
                                     input logic st, input logic pr,
                                     input logic [1:0] ctc, input logic [1:0] stc);
    return {18'h0, stc, ctc, 1'b0, pr, 1'b0, st, md, ch};
  endfunction

  function automatic logic [31:0] ex(input logic [3:0] ch);
    return {16'h0, ch, 2'b00, ch, 6'h15};
  endfunction

  initial
  begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    final_report();
  end

  initial
  begin
    logic [31:0] v;
    logic [1:0]  r;
    int          d;
    int          m;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    port_pins = 16'ha5c3;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, v, r);
    chk({31'h0, v[7]}, 32'h1);
    repeat (100) @(posedge aclk);
    rd(8'h00, v, r);
    chk({31'h0, v[7]}, 32'h0);
    rd(8'h18, v, r);
    chk({30'h0, r}, 32'h2);
    wr(8'h04, 32'h0, r);
    chk({30'h0, r}, 32'h2);
    rd(8'h14, v, r);
    chk(v, 32'h0000a5c3);
    wr(8'h10, 32'h7, r);
    for (int i = 0; i < 4; i++)
    begin
      d = div_t[i];
      m = 2 << stc_t[i];
      wr(8'h00, cw(4'(i + 4), 2'h0, 1'b1, 1'b0, 2'(ctc_t[i]), 2'(stc_t[i])), r);
      wst(0);
      chk({31'h0, irq_q}, 32'h1);
      rd(8'h04, v, r);
      chk(v, ex(4'(i + 4)));
      for (int j = 0; j < 2000 && ana_calibrate_q !== 1'b0; j++) @(posedge aclk);
      @(posedge aclk);
      chk(32'(c_len), 32'(14 * d));
      // the transfer's four half periods fall inside the first calibration clock
      chk(32'(k_len), 32'(4 * d - 4));
      // first phase may start up to one tick late against the free-running divider
      chk({31'h0, s_len > (m - 1) * d && s_len <= m * d}, 32'h1);
      wr(8'h0c, 32'h7, r);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq_q}, 32'h0);
    end
    wr(8'h00, cw(4'h3, 2'h2, 1'b1, 1'b1, 2'h0, 2'h0), r);
    for (int j = 3; j >= 0; j--)
    begin
      wst(0);
      wr(8'h0c, 32'h1, r);
      rd(8'h04, v, r);
      chk(v, ex(4'(j)));
    end
    wr(8'h00, cw(4'h2, 2'h1, 1'b1, 1'b0, 2'h0, 2'h0), r);
    wst(1);
    wr(8'h10, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    wr(8'h10, 32'h7, r);
    wr(8'h00, cw(4'h2, 2'h1, 1'b0, 1'b0, 2'h0, 2'h0) | 32'h00064000, r);
    wst(2);
    rd(8'h08, v, r);
    chk(v, ex(4'h9));
    wr(8'h0c, 32'h1, r);
    wst(0);
    rd(8'h04, v, r);
    chk(v, ex(4'h2));
    // leave continuous mode: a non-starting single write stops at the next result
    wr(8'h00, cw(4'h2, 2'h0, 1'b0, 1'b0, 2'h0, 2'h0), r);
    for (int i = 0; i < 2000; i++)
    begin
      rd(8'h00, v, r);
      if (v[7] === 1'b0) break;
    end
    chk({31'h0, v[7]}, 32'h0);
    rd(8'h04, v, r);
    wr(8'h0c, 32'h7, r);
    wr(8'h00, cw(4'h1, 2'h3, 1'b1, 1'b0, 2'h0, 2'h0) | 32'h00000200, r);
    wst(0);
    // long enough for the next scan result to be parked in the hold buffer
    repeat (1200) @(posedge aclk);
    rd(8'h04, v, r);
    chk(v, ex(4'h1));
    rd(8'h04, v, r);
    chk(v, ex(4'h0));
    rd(8'h0c, v, r);
    chk({31'h0, v[1]}, 32'h0);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(8'h00, cw(4'h5, 2'h0, 1'b1, 1'b0, 2'h0, 2'h0), r);
    wst(0);
    // calibration phase is over, but the interrupted reset calibration still runs
    repeat (100) @(posedge aclk);
    rd(8'h00, v, r);
    chk({31'h0, v[7]}, 32'h1);
    repeat (100) @(posedge aclk);
    rd(8'h00, v, r);
    chk({31'h0, v[7]}, 32'h0);
    final_report();
  end
endmodule
